// ==== rtl/dmc_pkg.sv ====
// constants and types used by the dma end, the link interface and the bench
package dmc_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NCH      = 8;
  localparam int NREQ     = 8;
  localparam int NBUS     = 3;
  localparam int NLINK    = 2;
  localparam int FDEPTH   = 16;
  localparam int FWIDTH   = 70;
  // ------------------------------------------------------------
  // register indices, word address = index * 4
  // ------------------------------------------------------------
  localparam logic [1:0] R_SRC     = 2'h0;
  localparam logic [1:0] R_DST     = 2'h1;
  localparam logic [1:0] R_CTL     = 2'h2;
  localparam logic [1:0] R_CNT     = 2'h3;
  localparam logic [5:0] IDX_BUSPRI  = 6'h20;
  localparam logic [5:0] IDX_CHK_IN  = 6'h21;
  localparam logic [5:0] IDX_CHK_RES = 6'h22;
  localparam int BRIDGE_BIT = 31;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int C_EN    = 0;
  localparam int C_CONT  = 1;
  localparam int C_PRIO  = 2;
  localparam int C_SIZE  = 3;
  localparam int C_SMOD  = 5;
  localparam int C_DMOD  = 7;
  localparam int C_SEL   = 9;
  localparam int C_HWEN  = 12;
  localparam int C_SWREQ = 13;
  localparam int C_SBUS  = 14;
  localparam int C_DBUS  = 16;
  localparam int C_CIRC  = 18;
  localparam int C_PEND  = 30;
  localparam int C_BUSY  = 31;
  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] AM_FIX  = 2'h0;
  localparam logic [1:0] AM_INC  = 2'h1;
  localparam logic [1:0] AM_DEC  = 2'h2;
  localparam logic [1:0] AM_CIRC = 2'h3;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] BUS_SYS  = 2'h0;
  localparam logic [1:0] BUS_DMA  = 2'h1;
  localparam logic [1:0] BUS_LINK = 2'h2;
  localparam logic [31:0] CHK_LINK_ADDR = 32'hF000_0000;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  typedef enum logic {ENG_IDLE = 1'b0, ENG_BUSY = 1'b1} dmc_eng_t;
endpackage

// ==== rtl/dmc_if.sv ====
// link between the dma end and the bus-side end
`timescale 1ns/1ps
`default_nettype none
interface dmc_if;
  logic                                reg_req;
  logic                                reg_we;
  logic [31:0]                         reg_addr;
  logic [31:0]                         reg_wdata;
  logic [31:0]                         reg_rdata;
  logic                                reg_ack;
  logic [dmc_pkg::NREQ-1:0]            hw_req;
  logic [dmc_pkg::NLINK-1:0]           link_ev;
  logic [dmc_pkg::NCH+dmc_pkg::NLINK-1:0] srq;
  logic [dmc_pkg::NBUS-1:0]            bus_req;
  logic [dmc_pkg::NBUS-1:0]            bus_we;
  logic [dmc_pkg::NBUS-1:0]            bus_ack;
  logic [dmc_pkg::NBUS-1:0][31:0]      bus_addr;
  logic [dmc_pkg::NBUS-1:0][31:0]      bus_wdata;
  logic [dmc_pkg::NBUS-1:0][31:0]      bus_rdata;
  logic [dmc_pkg::NBUS-1:0][1:0]       bus_size;
  logic [dmc_pkg::NBUS-1:0][1:0]       bus_pri;
  modport dev (input reg_req, reg_we, reg_addr, reg_wdata, hw_req, link_ev, bus_ack, bus_rdata,
               output reg_rdata, reg_ack, srq, bus_req, bus_we, bus_addr, bus_wdata, bus_size,
               bus_pri);
  modport far (output reg_req, reg_we, reg_addr, reg_wdata, hw_req, link_ev, bus_ack, bus_rdata,
               input reg_rdata, reg_ack, srq, bus_req, bus_we, bus_addr, bus_wdata, bus_size,
               bus_pri);
endinterface // dmc_if
`default_nettype wire

// ==== rtl/dmc_dev.sv ====
// eight-channel dma engine with move buffer and memory checker
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// move buffer
// ------------------------------------------------------------
module dmc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem[rp_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
    end else if (in_valid && in_ready) begin
      wp_r <= wp_r + 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp_r <= '0;
    end else if (out_valid && out_ready) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule // dmc_fifo

module dmc_dev (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  reset,
  // link to the bus side
  dmc_if.dev         lk,
  // status
  output logic [7:0]  ch_done,
  output logic [31:0] chk_result,
  output logic        eng_busy
);
  localparam int NCH = dmc_pkg::NCH;
  localparam logic [31:0] SWREQ_MASK = 32'h1 << dmc_pkg::C_SWREQ;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0]           src_r [NCH];
  logic [31:0]           dst_r [NCH];
  logic [31:0]           ctl_r [NCH];
  logic [31:0]           cnt_r [NCH];
  logic [NCH-1:0]        swp_r;
  logic [NCH-1:0]        done_r;
  logic [5:0]            busp_r;
  logic [31:0]           crc_r;
  logic                  ack_r;
  logic [31:0]           rdat_r;
  logic                  brq_r;
  logic                  br_we_r;
  logic [31:0]           br_addr_r;
  logic [31:0]           br_data_r;
  dmc_pkg::dmc_eng_t     rd_st_r;
  dmc_pkg::dmc_eng_t     wr_st_r;
  logic [2:0]            ch_r;
  logic [1:0]            rbus_r;
  logic [1:0]            wbus_r;
  logic                  wbr_r;
  logic [2:0]            bus_req_r;
  logic [2:0]            bus_we_r;
  logic [2:0]            bus_own_r;
  logic [2:0][31:0]      bus_addr_r;
  logic [2:0][31:0]      bus_wdata_r;
  logic [2:0][1:0]       bus_size_r;
  logic [1:0]            lev_r;
  logic                  busy_r;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] adv(input logic [31:0] a, input logic [1:0] md,
                                      input logic [1:0] sz, input logic [3:0] cl);
    logic [31:0] st;
    logic [31:0] mk;
    st = 32'h1 << sz;
    mk = (32'h1 << cl) - 32'h1;
    unique case (md)
      dmc_pkg::AM_FIX:  adv = a;
      dmc_pkg::AM_INC:  adv = a + st;
      dmc_pkg::AM_DEC:  adv = a - st;
      dmc_pkg::AM_CIRC: adv = (a & ~mk) | ((a + st) & mk);
    endcase
  endfunction
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] x;
    x = c;
    for (int k = 31; k >= 0; k--) begin
      x = {x[30:0], 1'b0} ^ ((x[31] ^ d[k]) ? dmc_pkg::CRC_POLY : 32'h0);
    end
    crc_step = x;
  endfunction
  // ------------------------------------------------------------
  // decode and arbitration
  // ------------------------------------------------------------
  logic [5:0]     ridx;
  logic           loc_hit;
  logic           loc_wr;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] cand;
  logic           g_any;
  logic [2:0]     g_idx;
  logic [1:0]     sbus;
  always_comb begin
    ridx    = lk.reg_addr[7:2];
    loc_hit = lk.reg_req && !lk.reg_addr[dmc_pkg::BRIDGE_BIT];
    loc_wr  = loc_hit && lk.reg_we;
    for (int i = 0; i < NCH; i++) begin
      pend[i] = ctl_r[i][dmc_pkg::C_EN] && (cnt_r[i] != 32'h0) && (swp_r[i] ||
                (ctl_r[i][dmc_pkg::C_HWEN] && lk.hw_req[ctl_r[i][dmc_pkg::C_SEL +: 3]]));
      cand[i] = pend[i] && ctl_r[i][dmc_pkg::C_PRIO];
    end
    if (cand == '0) begin
      cand = pend;
    end
    g_any = |cand;
    g_idx = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (cand[i]) begin
        g_idx = 3'(i);
      end
    end
    sbus = ctl_r[g_idx][dmc_pkg::C_SBUS +: 2];
  end
  // ------------------------------------------------------------
  // move buffer and engine handshakes
  // ------------------------------------------------------------
  logic [dmc_pkg::FWIDTH-1:0] f_in;
  logic [dmc_pkg::FWIDTH-1:0] f_out;
  logic f_in_ready;
  logic f_out_valid;
  logic h_rd;
  logic h_br;
  logic [1:0] h_bus;
  logic [1:0] h_size;
  logic [31:0] h_addr;
  logic [31:0] h_data;
  logic w_chk;
  logic w_start;
  logic r_start;
  logic br_push;
  logic r_ack;
  logic w_ack;
  assign {h_rd, h_br, h_bus, h_size, h_addr, h_data} = f_out;
  assign w_chk   = (h_bus == dmc_pkg::BUS_LINK) && (h_addr == dmc_pkg::CHK_LINK_ADDR)
                   && !h_rd && !h_br;
  assign w_start = (wr_st_r == dmc_pkg::ENG_IDLE) && f_out_valid && (w_chk || !bus_req_r[h_bus]);
  assign br_push = (rd_st_r == dmc_pkg::ENG_IDLE) && brq_r && f_in_ready;
  assign r_start = (rd_st_r == dmc_pkg::ENG_IDLE) && !brq_r && g_any && f_in_ready
                   && !bus_req_r[sbus] && !(w_start && !w_chk && h_bus == sbus);
  assign r_ack   = (rd_st_r == dmc_pkg::ENG_BUSY) && lk.bus_ack[rbus_r] && !bus_own_r[rbus_r];
  assign w_ack   = (wr_st_r == dmc_pkg::ENG_BUSY) && lk.bus_ack[wbus_r] && bus_own_r[wbus_r];
  assign f_in = br_push ? {!br_we_r, 1'b1, dmc_pkg::BUS_DMA, dmc_pkg::SZ_WORD, br_addr_r, br_data_r}
              : {1'b0, 1'b0, ctl_r[ch_r][dmc_pkg::C_DBUS +: 2], ctl_r[ch_r][dmc_pkg::C_SIZE +: 2],
                 dst_r[ch_r], lk.bus_rdata[rbus_r]};
  dmc_fifo #(.W(dmc_pkg::FWIDTH), .D(dmc_pkg::FDEPTH)) u_fifo (
    .clk       (sys_clk),
    .rst       (reset),
    .in_valid  (br_push || r_ack),
    .in_data   (f_in),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out),
    .out_ready (w_start)
  );
  // ------------------------------------------------------------
  // channel registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        src_r[i] <= 32'h0;
        dst_r[i] <= 32'h0;
        ctl_r[i] <= 32'h0;
        cnt_r[i] <= 32'h0;
      end
      swp_r  <= '0;
      done_r <= '0;
    end else begin
      done_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        if (r_ack && ch_r == 3'(i)) begin
          src_r[i] <= adv(src_r[i], ctl_r[i][dmc_pkg::C_SMOD +: 2], ctl_r[i][dmc_pkg::C_SIZE +: 2],
                          ctl_r[i][dmc_pkg::C_CIRC +: 4]);
          dst_r[i] <= adv(dst_r[i], ctl_r[i][dmc_pkg::C_DMOD +: 2], ctl_r[i][dmc_pkg::C_SIZE +: 2],
                          ctl_r[i][dmc_pkg::C_CIRC +: 4]);
          cnt_r[i] <= cnt_r[i] - 32'h1;
          swp_r[i] <= 1'b0;
          if (cnt_r[i] == 32'h1) begin
            done_r[i] <= 1'b1;
            if (!ctl_r[i][dmc_pkg::C_CONT]) begin
              ctl_r[i][dmc_pkg::C_EN] <= 1'b0;
            end
          end
        end
        if (loc_wr && ridx == {1'b0, 3'(i), dmc_pkg::R_SRC}) begin
          src_r[i] <= lk.reg_wdata;
        end
        if (loc_wr && ridx == {1'b0, 3'(i), dmc_pkg::R_DST}) begin
          dst_r[i] <= lk.reg_wdata;
        end
        if (loc_wr && ridx == {1'b0, 3'(i), dmc_pkg::R_CNT}) begin
          cnt_r[i] <= lk.reg_wdata;
        end
        if (loc_wr && ridx == {1'b0, 3'(i), dmc_pkg::R_CTL}) begin
          ctl_r[i] <= lk.reg_wdata & ~SWREQ_MASK;
          if (lk.reg_wdata[dmc_pkg::C_SWREQ]) begin
            swp_r[i] <= 1'b1;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // register port, bridge and checker
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0;
      busp_r    <= 6'h0;
      brq_r     <= 1'b0;
      br_we_r   <= 1'b0;
      br_addr_r <= 32'h0;
      br_data_r <= 32'h0;
      lev_r     <= '0;
    end else begin
      lev_r <= lk.link_ev;
      ack_r <= loc_hit || (w_ack && wbr_r);
      if (w_ack && wbr_r) begin
        rdat_r <= lk.bus_rdata[wbus_r];
      end else if (loc_hit && !ridx[5]) begin
        unique case (ridx[1:0])
          dmc_pkg::R_SRC: rdat_r <= src_r[ridx[4:2]];
          dmc_pkg::R_DST: rdat_r <= dst_r[ridx[4:2]];
          dmc_pkg::R_CNT: rdat_r <= cnt_r[ridx[4:2]];
          dmc_pkg::R_CTL: begin
            rdat_r <= ctl_r[ridx[4:2]];
            rdat_r[dmc_pkg::C_PEND] <= swp_r[ridx[4:2]];
            rdat_r[dmc_pkg::C_BUSY] <= (rd_st_r == dmc_pkg::ENG_BUSY) && (ch_r == ridx[4:2]);
          end
        endcase
      end else if (loc_hit) begin
        rdat_r <= (ridx == dmc_pkg::IDX_BUSPRI) ? {26'h0, busp_r}
                : (ridx == dmc_pkg::IDX_CHK_RES) ? crc_r : 32'h0;
      end
      if (loc_wr && ridx == dmc_pkg::IDX_BUSPRI) begin
        busp_r <= lk.reg_wdata[5:0];
      end
      if (lk.reg_req && lk.reg_addr[dmc_pkg::BRIDGE_BIT]) begin
        brq_r     <= 1'b1;
        br_we_r   <= lk.reg_we;
        br_addr_r <= lk.reg_addr;
        br_data_r <= lk.reg_wdata;
      end else if (br_push) begin
        brq_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crc_r <= dmc_pkg::CRC_INIT;
    end else if (loc_wr && ridx == dmc_pkg::IDX_CHK_RES) begin
      crc_r <= lk.reg_wdata;
    end else if (loc_wr && ridx == dmc_pkg::IDX_CHK_IN) begin
      crc_r <= crc_step(crc_r, lk.reg_wdata);
    end else if (w_start && w_chk) begin
      crc_r <= crc_step(crc_r, h_data);
    end
  end
  // ------------------------------------------------------------
  // read and write engines, bus switch
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_st_r <= dmc_pkg::ENG_IDLE;
      ch_r    <= 3'h0;
      rbus_r  <= 2'h0;
    end else if (r_start) begin
      rd_st_r <= dmc_pkg::ENG_BUSY;
      ch_r    <= g_idx;
      rbus_r  <= sbus;
    end else if (r_ack) begin
      rd_st_r <= dmc_pkg::ENG_IDLE;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_st_r <= dmc_pkg::ENG_IDLE;
      wbus_r  <= 2'h0;
      wbr_r   <= 1'b0;
    end else if (w_start && !w_chk) begin
      wr_st_r <= dmc_pkg::ENG_BUSY;
      wbus_r  <= h_bus;
      wbr_r   <= h_br;
    end else if (w_ack) begin
      wr_st_r <= dmc_pkg::ENG_IDLE;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_req_r   <= '0;
      bus_we_r    <= '0;
      bus_own_r   <= '0;
      bus_addr_r  <= '0;
      bus_wdata_r <= '0;
      bus_size_r  <= '0;
      busy_r      <= 1'b0;
    end else begin
      busy_r <= (rd_st_r == dmc_pkg::ENG_BUSY) || (wr_st_r == dmc_pkg::ENG_BUSY) || f_out_valid;
      for (int b = 0; b < dmc_pkg::NBUS; b++) begin
        if (r_start && sbus == 2'(b)) begin
          bus_req_r[b]   <= 1'b1;
          bus_we_r[b]    <= 1'b0;
          bus_own_r[b]   <= 1'b0;
          bus_addr_r[b]  <= src_r[g_idx];
          bus_wdata_r[b] <= 32'h0;
          bus_size_r[b]  <= ctl_r[g_idx][dmc_pkg::C_SIZE +: 2];
        end else if (w_start && !w_chk && h_bus == 2'(b)) begin
          bus_req_r[b]   <= 1'b1;
          bus_we_r[b]    <= !h_rd;
          bus_own_r[b]   <= 1'b1;
          bus_addr_r[b]  <= h_addr;
          bus_wdata_r[b] <= h_data;
          bus_size_r[b]  <= h_size;
        end else if (lk.bus_ack[b]) begin
          bus_req_r[b] <= 1'b0;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign lk.reg_ack   = ack_r;
  assign lk.reg_rdata = rdat_r;
  assign lk.srq       = {lev_r, done_r};
  assign lk.bus_req   = bus_req_r;
  assign lk.bus_we    = bus_we_r;
  assign lk.bus_addr  = bus_addr_r;
  assign lk.bus_wdata = bus_wdata_r;
  assign lk.bus_size  = bus_size_r;
  assign lk.bus_pri   = busp_r;
  assign ch_done      = done_r;
  assign chk_result   = crc_r;
  assign eng_busy     = busy_r;
endmodule // dmc_dev
`default_nettype wire

// ==== rtl/dmc_far.sv ====
// bus-side end: register master, request wiring and bus slaves
`timescale 1ns/1ps
`default_nettype none
module dmc_far (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // link to the dma end
  dmc_if.far               lk,
  // register command
  input  wire logic        u_req,
  input  wire logic        u_we,
  input  wire logic [31:0] u_addr,
  input  wire logic [31:0] u_wdata,
  output logic             u_ack,
  output logic [31:0]      u_rdata,
  output logic             u_busy,
  // request and event wiring
  input  wire logic [7:0]  u_hw_req,
  input  wire logic [1:0]  u_link_ev,
  output logic [9:0]       u_srq,
  // bus slaves
  output logic [2:0]       u_bus_req,
  output logic [2:0]       u_bus_we,
  output logic [2:0][31:0] u_bus_addr,
  output logic [2:0][31:0] u_bus_wdata,
  output logic [2:0][1:0]  u_bus_size,
  output logic [2:0][1:0]  u_bus_pri,
  input  wire logic [2:0]  u_bus_ack,
  input  wire logic [2:0][31:0] u_bus_rdata
);
  // ------------------------------------------------------------
  // register master
  // ------------------------------------------------------------
  logic        req_r;
  logic        we_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic        out_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= 32'h0;
      wdata_r <= 32'h0;
      out_r   <= 1'b0;
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      req_r <= 1'b0;
      ack_r <= lk.reg_ack;
      if (lk.reg_ack) begin
        out_r   <= 1'b0;
        rdata_r <= lk.reg_rdata;
      end else if (u_req && !out_r) begin
        req_r   <= 1'b1;
        we_r    <= u_we;
        addr_r  <= u_addr;
        wdata_r <= u_wdata;
        out_r   <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // request wiring and bus slaves
  // ------------------------------------------------------------
  logic [7:0]       hw_r;
  logic [1:0]       lev_r;
  logic [9:0]       srq_r;
  logic [2:0]       breq_r;
  logic [2:0]       bwe_r;
  logic [2:0][31:0] baddr_r;
  logic [2:0][31:0] bwd_r;
  logic [2:0][1:0]  bsz_r;
  logic [2:0][1:0]  bpri_r;
  logic [2:0]       bak_r;
  logic [2:0][31:0] brd_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hw_r    <= '0;
      lev_r   <= '0;
      srq_r   <= '0;
      breq_r  <= '0;
      bwe_r   <= '0;
      baddr_r <= '0;
      bwd_r   <= '0;
      bsz_r   <= '0;
      bpri_r  <= '0;
      bak_r   <= '0;
      brd_r   <= '0;
    end else begin
      hw_r    <= u_hw_req;
      lev_r   <= u_link_ev;
      srq_r   <= lk.srq;
      breq_r  <= lk.bus_req & ~bak_r & ~(u_bus_ack & breq_r);
      bwe_r   <= lk.bus_we;
      baddr_r <= lk.bus_addr;
      bwd_r   <= lk.bus_wdata;
      bsz_r   <= lk.bus_size;
      bpri_r  <= lk.bus_pri;
      bak_r   <= u_bus_ack & breq_r & lk.bus_req & ~bak_r;
      brd_r   <= u_bus_rdata;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign lk.reg_req   = req_r;
  assign lk.reg_we    = we_r;
  assign lk.reg_addr  = addr_r;
  assign lk.reg_wdata = wdata_r;
  assign lk.hw_req    = hw_r;
  assign lk.link_ev   = lev_r;
  assign lk.bus_ack   = bak_r;
  assign lk.bus_rdata = brd_r;
  assign u_ack        = ack_r;
  assign u_rdata      = rdata_r;
  assign u_busy       = out_r;
  assign u_srq        = srq_r;
  assign u_bus_req    = breq_r;
  assign u_bus_we     = bwe_r;
  assign u_bus_addr   = baddr_r;
  assign u_bus_wdata  = bwd_r;
  assign u_bus_size   = bsz_r;
  assign u_bus_pri    = bpri_r;
endmodule // dmc_far
`default_nettype wire

// ==== bench/dmc_props.sv ====
// assertions on the dma link
`timescale 1ns/1ps
`default_nettype none
module dmc_props (
  input wire logic             sys_clk, reset, reg_req, reg_ack,
  input wire logic [31:0]      reg_addr,
  input wire logic [1:0]       link_ev,
  input wire logic [9:0]       srq,
  input wire logic [2:0]       bus_req, bus_ack,
  input wire logic [2:0][31:0] bus_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_brg; reg_req && reg_addr[31]; endsequence
  loc_ack_a: assert property (reg_req && !reg_addr[31] |=> reg_ack) else $error("ack");
  ack_len_a: assert property (reg_ack |=> !reg_ack) else $error("ack len");
  brg_bus_a: assert property (s_brg |-> ##[1:8] bus_req[1]) else $error("bridge");
  brg_ack_a: assert property (s_brg |=> !reg_ack[*2] ##[1:60] reg_ack) else $error("brg ack");
  evt_dly_a: assert property (1'b1 |=> srq[9:8] == $past(link_ev)) else $error("event");
  req_hold_a: assert property (bus_req[0] && !bus_ack[0] |=> bus_req[0]) else $error("hold");
  addr_hold_a: assert property (bus_req[1] && !bus_ack[1] |=> $stable(bus_addr[1]))
    else $error("addr");
  ack_req_a: assert property (bus_ack[0] |-> bus_req[0]) else $error("stray ack");
  req_drop_a: assert property (bus_ack[0] |=> !bus_req[0]) else $error("drop");
endmodule // dmc_props
`default_nettype wire

// ==== bench/test_dma_with_memory_checksum.sv ====
// self-checking bench for both ends of the dma link
`timescale 1ns/1ps
`default_nettype none
module test_dma_with_memory_checksum;
  localparam logic [31:0] K = 32'h5A5A_0000;
  logic sys_clk, reset, u_req, u_we, u_ack, u_busy, eng_busy;
  logic [31:0] u_addr, u_wdata, u_rdata, q, c, chk_result, wseen;
  logic [7:0] u_hw_req, ch_done;
  logic [1:0] u_link_ev;
  logic [9:0] u_srq;
  logic [2:0] u_bus_req, u_bus_we, u_bus_ack, hold;
  logic [2:0][31:0] u_bus_addr, u_bus_wdata, u_bus_rdata;
  logic [2:0][1:0] u_bus_size, u_bus_pri;
  int err_count, check_count;
  dmc_if lk ();
  dmc_dev i_dmc_dev (.sys_clk, .reset, .lk(lk.dev), .ch_done, .chk_result, .eng_busy);
  dmc_far i_dmc_far (.sys_clk, .reset, .lk(lk.far), .u_req, .u_we, .u_addr, .u_wdata, .u_ack,
    .u_rdata, .u_busy, .u_hw_req, .u_link_ev, .u_srq, .u_bus_req, .u_bus_we, .u_bus_addr,
    .u_bus_wdata, .u_bus_size, .u_bus_pri, .u_bus_ack, .u_bus_rdata);
  dmc_props i_dmc_props (.sys_clk, .reset, .reg_req(lk.reg_req), .reg_ack(lk.reg_ack),
    .reg_addr(lk.reg_addr), .link_ev(lk.link_ev), .srq(lk.srq), .bus_req(lk.bus_req),
    .bus_ack(lk.bus_ack), .bus_addr(lk.bus_addr));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // bus slaves: one ack per request, data from address
  always @(negedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      u_bus_ack[i] = u_bus_req[i] && !hold[i];
      u_bus_rdata[i] = u_bus_addr[i] ^ K;
      if (u_bus_ack[i] && u_bus_we[i]) wseen = u_bus_wdata[i] ^ {30'h0, u_bus_size[i]};
      hold[i] = u_bus_req[i] && (hold[i] || u_bus_ack[i]);
    end
  end
  function automatic logic [31:0] crc(input logic [31:0] s, d);
    for (int i = 31; i >= 0; i--) s = (s << 1) ^ ((s[31] ^ d[i]) ? dmc_pkg::CRC_POLY : 32'h0);
    return s;
  endfunction
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [31:0] a, d);
    int k;
    k = 0;
    @(negedge sys_clk);
    u_req = 1; u_we = w; u_addr = a; u_wdata = d;
    do @(negedge sys_clk); while (u_ack !== 1'b1 && ++k < 200);
    q = u_rdata;
    u_req = 0;
    chk(u_ack, 1);
  endtask
  task wdone(input int ch);
    int k;
    k = 0;
    do @(negedge sys_clk); while (ch_done[ch] !== 1'b1 && ++k < 500);
    chk(ch_done[ch], 1);
    u_hw_req = 0;
    repeat (4) @(negedge sys_clk);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    err_count++;
    print_verdict;
  end
  initial begin
    reset = 1; u_req = 0; u_we = 0; u_addr = 0; u_wdata = 0; u_hw_req = 0; u_link_ev = 0;
    err_count = 0; check_count = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) reset = 0;
    chk(chk_result, 32'hFFFF_FFFF);
    acc(1, 32'h0, 32'hFFFF_FFFC); acc(0, 32'h0, 0); chk(q, 32'hFFFF_FFFC);
    acc(0, 32'h8C, 0); chk(q, 0);
    c = crc(32'hFFFF_FFFF, 32'h1234_5678);
    acc(1, 32'h84, 32'h1234_5678); acc(0, 32'h88, 0); chk(q, c);
    $display("test registers and checker done");
    acc(1, 32'h10, 32'h100); acc(1, 32'h14, dmc_pkg::CHK_LINK_ADDR); acc(1, 32'h1C, 2);
    acc(1, 32'h18, 32'h0002_2031); repeat (12) @(negedge sys_clk);
    acc(1, 32'h18, 32'h0002_2031); wdone(1);
    c = crc(crc(c, 32'h100 ^ K), 32'h104 ^ K); chk(chk_result, c);
    acc(0, 32'h18, 0); chk(q[0], 0);
    acc(0, 32'h1C, 0); chk(q, 0);
    $display("test single move done");
    acc(1, 32'h20, 32'h20C); acc(1, 32'h24, dmc_pkg::CHK_LINK_ADDR); acc(1, 32'h2C, 1);
    acc(1, 32'h28, 32'h000E_1673); u_hw_req = 8'h08; wdone(2);
    c = crc(c, 32'h20C ^ K); chk(chk_result, c);
    acc(0, 32'h20, 0); chk(q, 32'h208);
    acc(0, 32'h28, 0); chk(q[0], 1);
    $display("test continuous hardware move done");
    acc(1, 32'h80, 32'h39); repeat (3) @(negedge sys_clk); chk(u_bus_pri, 32'h39);
    u_link_ev = 2'h2;
    @(negedge sys_clk) u_link_ev = 0;
    repeat (2) @(negedge sys_clk); chk(u_srq, 32'h200);
    acc(0, 32'h8000_0040, 0); chk(q, 32'h8000_0040 ^ K);
    acc(1, 32'h8000_0044, 32'hCAFE_0001);
    chk(wseen, 32'hCAFE_0001 ^ {30'h0, dmc_pkg::SZ_WORD});
    chk(eng_busy, 0);
    $display("test priority and bridge done");
    print_verdict;
  end
endmodule // test_dma_with_memory_checksum
`default_nettype wire
